// [rtl/xoe_defs.svh]
// Purpose: constants of the extended opcode executor
// Assumes: APB byte addresses, one word per register
// Notes:   opcode values are the low byte after the prefix
//
// Behaviour
// - Prefix byte FE makes the next byte an extended opcode.
// - FE85..FE87 take a status byte; user function continues only on match.
// - FE88 table lookup, only inside a user function, float or long.
// - FE89 polynomial on float accumulator, coefficients in user function.
// - FE90 returns low 8 bits of the accumulator.
// - FE91 returns low 16 bits of the accumulator.
// - FE92/FE93 return all 32 bits, as long or as float.
// - 32-bit values travel as two halves, high half first.
// - FE9D shifts the long accumulator by the operand register.
// - FEAx writes a value to register x and makes it accumulator.
// - FEBx writes a value to register x and makes it operand.
// - FEDx selects operand x, unsigned divide, remainder to register 0.
// - FEE0 power, FEE1 root of accumulator by operand.
// - FEE2 minimum, FEE3 maximum of accumulator and operand.
// - FEE4 puts fraction of accumulator in register 0, selects it.
// - FEE9/FEEA signed and unsigned compare, return status byte.
// - FEEB returns status byte of the long accumulator.
// - FEF0..FEF3 load zero, one, e, pi into register 0, select it.
// - FEF4..FEF7 extend byte or half into register 0, select it.
// - FEF8 standard float format, the reset mode; FEF9 alternate format.
// - FEFA checksum of stored code into register 0.
// - FEFC clears and FEFD sets the trace enable.
// - FEFE takes a zero-terminated string into the trace buffer.
// - FEFF puts the version text into the string buffer.
// - Operations with operand result 0 leave register 0 selected.
`ifndef XOE_DEFS_SVH
`define XOE_DEFS_SVH
`define XOE_EXTENDED_PREFIX      8'hFE
`define XOE_COND_EXEC_SIGNED_CMP 8'h85
`define XOE_COND_EXEC_UNSIGNED_CMP 8'h86
`define XOE_COND_EXEC_BIT_TEST   8'h87
`define XOE_TABLE_LOOKUP         8'h88
`define XOE_POLYNOMIAL_EVAL      8'h89
`define XOE_GET_LOW_BYTE         8'h90
`define XOE_GET_LOW_HALFWORD     8'h91
`define XOE_GET_LONG_VALUE       8'h92
`define XOE_GET_FLOAT_VALUE      8'h93
`define XOE_LONG_SHIFT_BY_OPERAND 8'h9D
`define XOE_WRITE_AND_SELECT_ACC 4'hA
`define XOE_WRITE_AND_SELECT_OPERAND 4'hB
`define XOE_UNSIGNED_LONG_DIVIDE 4'hD
`define XOE_POWER                8'hE0
`define XOE_ROOT                 8'hE1
`define XOE_MINIMUM              8'hE2
`define XOE_MAXIMUM              8'hE3
`define XOE_FRACTION             8'hE4
`define XOE_SIGNED_LONG_COMPARE  8'hE9
`define XOE_UNSIGNED_LONG_COMPARE 8'hEA
`define XOE_LONG_STATUS_QUERY    8'hEB
`define XOE_LOAD_CONST_ZERO      8'hF0
`define XOE_SIGNED_BYTE_TO_LONG  8'hF4
`define XOE_UNSIGNED_BYTE_TO_LONG 8'hF5
`define XOE_SIGNED_HALF_TO_LONG  8'hF6
`define XOE_UNSIGNED_HALF_TO_LONG 8'hF7
`define XOE_STANDARD_FLOAT_FORMAT 8'hF8
`define XOE_ALTERNATE_FLOAT_FORMAT 8'hF9
`define XOE_CHECKSUM             8'hFA
`define XOE_TRACE_DISABLE        8'hFC
`define XOE_TRACE_ENABLE         8'hFD
`define XOE_TRACE_TEXT_SEND      8'hFE
`define XOE_VERSION_COPY         8'hFF
`define XOE_K_ZERO               32'h00000000
`define XOE_K_ONE                32'h3F800000
`define XOE_K_EULER              32'h402DF854
`define XOE_K_CIRCLE             32'h40490FDB
`define XOE_OFF_CMD              8'h00
`define XOE_OFF_RESULT           8'h04
`define XOE_OFF_STATUS           8'h08
`define XOE_OFF_STRING           8'h0C
`define XOE_OFF_TRACE            8'h10
`define XOE_RST_FMT_ALT          1'b0
`define XOE_RST_TRACE_EN         1'b0
`define XOE_VERSION_TEXT         128'h584F452056312E300000000000000000
`endif

// [rtl/xoe_pkg.sv]
// Purpose: types of the extended opcode executor
// Assumes: constants live in xoe_defs.svh
// Notes:   two structs carry the math engine handshake, the third the status word
package xoe_pkg;
    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_OP   = 5'h02,
        S_ARG  = 5'h04,
        S_STR  = 5'h08,
        S_MATH = 5'h10
    } xoe_state_e;

    typedef struct packed {
        logic [7:0]  op;
        logic [31:0] a;
        logic [31:0] b;
    } xoe_math_req_s;

    typedef struct packed {
        logic [31:0] res;
        logic [31:0] rem;
    } xoe_math_resp_s;

    typedef struct packed {
        logic [4:0]  zero;
        logic        cond_pass;
        logic        trace_en;
        logic        fmt_alt;
        logic [3:0]  b_sel;
        logic [3:0]  a_sel;
        logic [2:0]  res_len;
        logic [7:0]  opcode;
        logic [4:0]  state;
    } xoe_stat_s;
endpackage

// [rtl/xoe_top.sv]
// Purpose: decode and execute the two-byte extended opcode set
// Assumes: bytes arrive by APB writes; numeric engine is outside
// Notes:   heavy float work is handed to the engine by request
`timescale 1ns/1ps
`include "xoe_defs.svh"

module xoe_top
    import xoe_pkg::*;
(
    input  wire logic           clk_sys,
    input  wire logic           reset_n,
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [7:0]     paddr,
    input  wire logic [31:0]    pwdata,
    output logic      [31:0]    prdata,
    output logic                pready,
    output logic                pslverr,
    input  wire logic           uf_active,
    output xoe_math_req_s       math_req,
    output logic                math_start,
    input  wire logic           math_done,
    input  wire xoe_math_resp_s math_resp,
    output logic                cond_done,
    output logic                cond_pass,
    output logic                trace_en,
    output logic                trace_valid,
    output logic      [7:0]     trace_code
);

    // Argument bytes that follow each opcode
    function automatic logic [2:0] arg_count(input logic [7:0] op);
        if (op[7:4] == `XOE_WRITE_AND_SELECT_ACC ||
            op[7:4] == `XOE_WRITE_AND_SELECT_OPERAND) begin
            arg_count = 3'h4;
        end else if (op == `XOE_SIGNED_HALF_TO_LONG ||
                     op == `XOE_UNSIGNED_HALF_TO_LONG) begin
            arg_count = 3'h2;
        end else if (op == `XOE_SIGNED_BYTE_TO_LONG ||
                     op == `XOE_UNSIGNED_BYTE_TO_LONG ||
                     (op >= `XOE_COND_EXEC_SIGNED_CMP &&
                      op <= `XOE_COND_EXEC_BIT_TEST)) begin
            arg_count = 3'h1;
        end else begin
            arg_count = 3'h0;
        end
    endfunction

    // Status byte: bit 0 zero or equal, bit 1 negative or less
    function automatic logic [7:0] stat_of(input logic z, input logic n);
        stat_of = {6'h00, n, z};
    endfunction

    // Float order on sign-magnitude words; both zeros count equal
    function automatic logic flt_lt(input logic [31:0] x, input logic [31:0] y);
        if (x[31] != y[31]) begin
            flt_lt = x[31] && ((x[30:0] | y[30:0]) != 31'h0);
        end else if (x[31]) begin
            flt_lt = x[30:0] > y[30:0];
        end else begin
            flt_lt = x[30:0] < y[30:0];
        end
    endfunction

    logic             rst_q1;
    logic             rst_n;
    xoe_state_e       st_reg;
    logic [7:0]       op_reg;
    logic [31:0]      arg_reg;
    logic [2:0]       cnt_reg;
    logic [3:0]       a_sel_reg;
    logic [3:0]       b_sel_reg;
    logic [31:0]      regs [16];
    logic [31:0]      res_reg;
    logic [2:0]       len_reg;
    logic             fmt_alt_reg;
    logic [127:0]     str_reg;
    logic [127:0]     trc_reg;

    // Reset release through two flops
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_q1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n  <= rst_q1;
        end
    end

    // Bus decode; a command byte stalls while the engine works
    wire        acc_ph  = psel & penable & ~pready;
    wire        fin     = psel & penable & pready;
    wire        a_cmd   = paddr == `XOE_OFF_CMD;
    wire        a_res   = paddr == `XOE_OFF_RESULT;
    wire        a_stat  = paddr == `XOE_OFF_STATUS;
    wire        a_str   = paddr == `XOE_OFF_STRING;
    wire        a_trc   = paddr == `XOE_OFF_TRACE;
    wire        rd_ok   = a_res | a_stat | a_str | a_trc;
    wire        bad     = pwrite ? ~a_cmd : ~rd_ok;
    wire        hold    = pwrite & a_cmd & (st_reg == S_MATH);
    wire        byte_in = fin & pwrite & a_cmd & ~pslverr;
    wire        res_pop = fin & ~pwrite & a_res;
    wire        str_pop = fin & ~pwrite & a_str;
    wire [7:0]  bval    = pwdata[7:0];

    // Completion of an opcode with all of its argument bytes
    wire        op_now  = byte_in & (st_reg == S_OP);
    wire        exec    = (op_now & (arg_count(bval) == 3'h0) &
                           (bval != `XOE_TRACE_TEXT_SEND)) |
                          (byte_in & (st_reg == S_ARG) & (cnt_reg == 3'h1));
    wire [7:0]  eop     = (st_reg == S_OP) ? bval : op_reg;
    wire [31:0] xarg    = {arg_reg[23:0], bval};
    wire [3:0]  xhi     = eop[7:4];
    wire [3:0]  xlo     = eop[3:0];

    // Operand views
    wire [31:0] ra      = regs[a_sel_reg];
    wire [31:0] rb      = regs[b_sel_reg];
    wire [31:0] ab      = ra & rb;
    wire        s_lt    = $signed(ra) < $signed(rb);
    wire [7:0]  st_scmp = stat_of(ra == rb, s_lt);
    wire [7:0]  st_ucmp = stat_of(ra == rb, ra < rb);
    wire [7:0]  st_long = stat_of(ra == 32'h00000000, ra[31]);
    wire [7:0]  st_bit  = stat_of(ab == 32'h00000000, ab[31]);
    wire [31:0] neg_b   = 32'h00000000 - rb;
    wire [31:0] shifted = rb[31] ? (ra >> neg_b) : (ra << rb);
    wire [31:0] fmin    = flt_lt(ra, rb) ? ra : rb;
    wire [31:0] fmax    = flt_lt(ra, rb) ? rb : ra;
    wire [31:0] f_alt   = {ra[30:23], ra[31], ra[22:0]};

    // Ops that go to the numeric engine; table and polynomial_eval need a user function
    wire        uf_op   = (eop == `XOE_TABLE_LOOKUP) | (eop == `XOE_POLYNOMIAL_EVAL);
    wire        eng_op  = (uf_op & uf_active) |
                          (xhi == `XOE_UNSIGNED_LONG_DIVIDE) |
                          (eop == `XOE_POWER) | (eop == `XOE_ROOT) |
                          (eop == `XOE_FRACTION) | (eop == `XOE_CHECKSUM);
    wire        go_eng  = exec & eng_op;
    wire        to_zero = (math_req.op == `XOE_FRACTION) |
                          (math_req.op == `XOE_CHECKSUM);
    wire        is_div  = math_req.op[7:4] == `XOE_UNSIGNED_LONG_DIVIDE;
    wire        eng_fin = (st_reg == S_MATH) & math_done;
    wire        cond_op = (eop >= `XOE_COND_EXEC_SIGNED_CMP) &
                          (eop <= `XOE_COND_EXEC_BIT_TEST);
    wire [7:0]  cond_st = (eop == `XOE_COND_EXEC_SIGNED_CMP) ? st_scmp :
                          (eop == `XOE_COND_EXEC_UNSIGNED_CMP) ? st_ucmp : st_bit;

    // Constant and small-integer loads into register 0
    wire        k_op    = eop[7:2] == 6'h3C;
    wire [31:0] k_val   = (xlo[1:0] == 2'h0) ? `XOE_K_ZERO :
                          (xlo[1:0] == 2'h1) ? `XOE_K_ONE :
                          (xlo[1:0] == 2'h2) ? `XOE_K_EULER : `XOE_K_CIRCLE;
    wire        x_op    = eop[7:2] == 6'h3D;
    wire [31:0] x_val   = (xlo[1:0] == 2'h0) ? {{24{xarg[7]}}, xarg[7:0]} :
                          (xlo[1:0] == 2'h1) ? {24'h000000, xarg[7:0]} :
                          (xlo[1:0] == 2'h2) ? {{16{xarg[15]}}, xarg[15:0]} :
                          {16'h0000, xarg[15:0]};

    // Read data for the access phase
    wire [31:0] res_rd  = (len_reg == 3'h4) ? {16'h0000, res_reg[31:16]} :
                          (len_reg == 3'h2) ? {16'h0000, res_reg[15:0]} :
                          (len_reg == 3'h1) ? {24'h000000, res_reg[7:0]} :
                          32'h00000000;
    xoe_stat_s  stat_w;
    assign stat_w = '{zero: 5'h00, cond_pass: cond_pass, trace_en: trace_en,
                      fmt_alt: fmt_alt_reg, b_sel: b_sel_reg, a_sel: a_sel_reg,
                      res_len: len_reg, opcode: op_reg, state: st_reg};
    wire [31:0] rd_val  = a_res  ? res_rd :
                          a_stat ? stat_w :
                          a_str  ? {24'h000000, str_reg[127:120]} :
                          a_trc  ? trc_reg[31:0] : 32'h00000000;

    // Bus answer one cycle into the access phase; a command write is held off by a busy engine
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= acc_ph & ~hold;
            pslverr <= acc_ph & ~hold & bad;
            prdata  <= (acc_ph & ~pwrite) ? rd_val : 32'h00000000;
        end
    end

    // Byte sequencer; only prefixed bytes are ours, others pass by
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_reg  <= S_IDLE;
            op_reg  <= 8'h00;
            arg_reg <= 32'h00000000;
            cnt_reg <= 3'h0;
        end else begin
            case (st_reg)
                S_IDLE: begin
                    if (byte_in && bval == `XOE_EXTENDED_PREFIX) begin
                        st_reg <= S_OP;
                    end
                end
                S_OP: begin
                    if (byte_in) begin
                        op_reg  <= bval;
                        cnt_reg <= arg_count(bval);
                        if (bval == `XOE_TRACE_TEXT_SEND) begin
                            st_reg <= S_STR;
                        end else if (arg_count(bval) != 3'h0) begin
                            st_reg <= S_ARG;
                        end else begin
                            st_reg <= go_eng ? S_MATH : S_IDLE;
                        end
                    end
                end
                S_ARG: begin
                    if (byte_in) begin
                        arg_reg <= xarg;
                        cnt_reg <= cnt_reg - 3'h1;
                        if (cnt_reg == 3'h1) begin
                            st_reg <= S_IDLE;
                        end
                    end
                end
                S_STR: begin
                    if (byte_in && bval == 8'h00) begin
                        st_reg <= S_IDLE;
                    end
                end
                S_MATH: begin
                    if (math_done) begin
                        st_reg <= S_IDLE;
                    end
                end
                default: st_reg <= S_IDLE;
            endcase
        end
    end

    // Register file; no reset, contents are undefined until written
    always_ff @(posedge clk_sys) begin
        if (exec && (xhi == `XOE_WRITE_AND_SELECT_ACC ||
                     xhi == `XOE_WRITE_AND_SELECT_OPERAND)) begin
            regs[xlo] <= xarg;
        end else if (exec && eop == `XOE_LONG_SHIFT_BY_OPERAND) begin
            regs[a_sel_reg] <= shifted;
        end else if (exec && eop == `XOE_MINIMUM) begin
            regs[a_sel_reg] <= fmin;
        end else if (exec && eop == `XOE_MAXIMUM) begin
            regs[a_sel_reg] <= fmax;
        end else if (exec && k_op) begin
            regs[0] <= k_val;
        end else if (exec && x_op) begin
            regs[0] <= x_val;
        end else if (eng_fin && to_zero) begin
            regs[0] <= math_resp.res;
        end else if (eng_fin) begin
            regs[a_sel_reg] <= math_resp.res;
            if (is_div) begin
                regs[0] <= math_resp.rem;
            end
        end
    end

    // Accumulator and operand selection
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            a_sel_reg <= 4'h0;
            b_sel_reg <= 4'h0;
        end else if (exec && xhi == `XOE_WRITE_AND_SELECT_ACC) begin
            a_sel_reg <= xlo;
        end else if (exec && (xhi == `XOE_WRITE_AND_SELECT_OPERAND ||
                              xhi == `XOE_UNSIGNED_LONG_DIVIDE)) begin
            b_sel_reg <= xlo;
        end else if ((exec && (k_op || x_op)) || (eng_fin && to_zero)) begin
            b_sel_reg <= 4'h0;
        end
    end

    // Readback word; a 32-bit value leaves as high half then low half
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            res_reg <= 32'h00000000;
            len_reg <= 3'h0;
        end else if (exec && eop == `XOE_GET_LOW_BYTE) begin
            res_reg <= ra;
            len_reg <= 3'h1;
        end else if (exec && eop == `XOE_GET_LOW_HALFWORD) begin
            res_reg <= ra;
            len_reg <= 3'h2;
        end else if (exec && eop == `XOE_GET_LONG_VALUE) begin
            res_reg <= ra;
            len_reg <= 3'h4;
        end else if (exec && eop == `XOE_GET_FLOAT_VALUE) begin
            res_reg <= fmt_alt_reg ? f_alt : ra;
            len_reg <= 3'h4;
        end else if (exec && eop == `XOE_SIGNED_LONG_COMPARE) begin
            res_reg <= {24'h000000, st_scmp};
            len_reg <= 3'h1;
        end else if (exec && eop == `XOE_UNSIGNED_LONG_COMPARE) begin
            res_reg <= {24'h000000, st_ucmp};
            len_reg <= 3'h1;
        end else if (exec && eop == `XOE_LONG_STATUS_QUERY) begin
            res_reg <= {24'h000000, st_long};
            len_reg <= 3'h1;
        end else if (res_pop) begin
            res_reg <= {16'h0000, res_reg[15:0]};
            len_reg <= (len_reg == 3'h4) ? 3'h2 : 3'h0;
        end
    end

    // Format mode, trace enable and the two text buffers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fmt_alt_reg <= `XOE_RST_FMT_ALT;
            trace_en    <= `XOE_RST_TRACE_EN;
            str_reg     <= 128'h0;
            trc_reg     <= 128'h0;
        end else begin
            if (exec && eop == `XOE_STANDARD_FLOAT_FORMAT) begin
                fmt_alt_reg <= 1'b0;
            end else if (exec && eop == `XOE_ALTERNATE_FLOAT_FORMAT) begin
                fmt_alt_reg <= 1'b1;
            end
            if (exec && eop == `XOE_TRACE_DISABLE) begin
                trace_en <= 1'b0;
            end else if (exec && eop == `XOE_TRACE_ENABLE) begin
                trace_en <= 1'b1;
            end
            // Text overwrites the oldest bytes; the buffer keeps the last 16
            if (byte_in && st_reg == S_STR && bval != 8'h00) begin
                trc_reg <= {trc_reg[119:0], bval};
            end
            if (exec && eop == `XOE_VERSION_COPY) begin
                str_reg <= `XOE_VERSION_TEXT;
            end else if (str_pop) begin
                str_reg <= {str_reg[119:0], 8'h00};
            end
        end
    end

    // Engine request, conditional result and trace report
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            math_req    <= '0;
            math_start  <= 1'b0;
            cond_done   <= 1'b0;
            cond_pass   <= 1'b0;
            trace_valid <= 1'b0;
            trace_code  <= 8'h00;
        end else begin
            math_start  <= go_eng;
            if (go_eng) begin
                math_req.op <= eop;
                math_req.a  <= ra;
                math_req.b  <= (xhi == `XOE_UNSIGNED_LONG_DIVIDE) ? regs[xlo] : rb;
            end
            // Outside a user function the condition codes are ignored
            cond_done   <= exec & cond_op & uf_active;
            if (exec && cond_op && uf_active) begin
                cond_pass <= cond_st == xarg[7:0];
            end
            trace_valid <= exec & trace_en;
            if (exec) begin
                trace_code <= eop;
            end
        end
    end

endmodule

// [tb/xoe_engine_model.sv]
// Purpose: behavioural numeric engine on the far side of the job port
// Assumes: one job at a time, answer DLY cycles after the start pulse
// Notes:   result a+b, remainder a^b; response churns while idle
`timescale 1ns/1ps
module xoe_engine_model
    import xoe_pkg::*;
#(
    parameter int DLY = 5
) (
    input  wire logic           clk_sys,
    input  wire logic           math_start,
    input  wire xoe_math_req_s  math_req,
    output logic                math_done,
    output xoe_math_resp_s      math_resp
);
    int cnt = 0;
    initial math_done = 1'b0;
    initial math_resp = '0;
    // Slow answer; between jobs the response inverts every cycle instead of holding the last answer
    always @(posedge clk_sys) begin
        math_done <= (cnt == 1);
        math_resp <= (cnt == 1) ? {math_req.a + math_req.b, math_req.a ^ math_req.b} : ~math_resp;
        cnt       <= math_start ? DLY : ((cnt > 0) ? cnt - 1 : 0);
    end
endmodule

// [tb/xoe_top_assertions.sv]
// Purpose: temporal checks at the executor ports
// Assumes: one clock, reset_n active low
// Notes:   bound to xoe_top after the module
`timescale 1ns/1ps
module xoe_top_assertions
    import xoe_pkg::*;
(
    input wire logic          clk_sys,
    input wire logic          reset_n,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [7:0]    paddr,
    input wire logic [31:0]   prdata,
    input wire logic          pready,
    input wire logic          pslverr,
    input wire logic          uf_active,
    input wire xoe_math_req_s math_req,
    input wire logic          math_start,
    input wire logic          cond_done,
    input wire logic          trace_valid
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    a_ready_needs_access: assert property (pready |-> $past(psel && penable))
        else $error("pready without access phase");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_idle_rdata_zero: assert property (!pready |-> prdata == 32'h00000000)
        else $error("prdata nonzero outside answer");
    a_job_after_cmd: assert property (math_start |-> $past(psel && penable && pwrite && pready && paddr == 8'h00))
        else $error("engine job without command write");
    a_job_single_pulse: assert property (math_start |=> !math_start)
        else $error("engine start longer than one cycle");
    a_lookup_needs_uf: assert property (math_start && math_req.op inside {8'h88, 8'h89} |-> $past(uf_active))
        else $error("table or polynomial outside user function");
    a_cond_needs_uf: assert property (cond_done |-> $past(uf_active))
        else $error("condition evaluated outside user function");
    a_trace_pulse_gap: assert property (trace_valid |=> !trace_valid)
        else $error("trace pulse too long");
endmodule

bind xoe_top xoe_top_assertions u_chk (.clk_sys, .reset_n, .psel, .penable, .pwrite, .paddr,
    .prdata, .pready, .pslverr, .uf_active, .math_req, .math_start, .cond_done, .trace_valid);

// [tb/test_extended_opcode_executor.sv]
// Purpose: self-checking bench for the extended opcode executor
// Assumes: APB master here, engine model answers after five cycles
// Notes:   table rows cover readback and compares; hand tests follow
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module test_extended_opcode_executor
    import xoe_pkg::*;
;
    typedef struct packed {logic [7:0] op; logic [1:0] n; logic [15:0] e0; logic [15:0] e1;} xoe_row_s;
    logic           clk_sys = 1'b0;
    logic           reset_n = 1'b0;
    logic           uf_active = 1'b0;
    logic [42:0]    bus = '0;
    logic [31:0]    prdata;
    logic [31:0]    rd;
    logic           pready;
    logic           pslverr;
    logic           err;
    xoe_math_req_s  math_req;
    xoe_math_resp_s math_resp;
    logic           math_start;
    logic           math_done;
    logic           cond_done;
    logic           cond_pass;
    logic           trace_en;
    logic           trace_valid;
    logic [7:0]     trace_code;
    int             bad_count = 0;
    int             compares = 0;
    int             seen_tv = 0;
    xoe_row_s       rows [7] = '{'{8'h90, 2'd1, 16'h0078, 16'h0}, '{8'h91, 2'd1, 16'h5678, 16'h0},
        '{8'h92, 2'd2, 16'h1234, 16'h5678}, '{8'h93, 2'd2, 16'h1234, 16'h5678},
        '{8'hE9, 2'd1, 16'h0001, 16'h0}, '{8'hEA, 2'd1, 16'h0001, 16'h0}, '{8'hEB, 2'd1, 16'h0000, 16'h0}};

    xoe_top dut (.clk_sys, .reset_n, .psel(bus[42]), .penable(bus[41]), .pwrite(bus[40]),
        .paddr(bus[39:32]), .pwdata(bus[31:0]), .prdata, .pready, .pslverr, .uf_active,
        .math_req, .math_start, .math_done, .math_resp, .cond_done, .cond_pass, .trace_en,
        .trace_valid, .trace_code);
    xoe_engine_model eng (.clk_sys, .math_start, .math_req, .math_done, .math_resp);

    // Clock, trace pulse counter and hang guard
    initial forever #20 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (trace_valid === 1'b1) seen_tv <= seen_tv + 1;
    initial begin
        repeat (20000) @(posedge clk_sys);
        bad_count++;
        close_out();
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        bus <= {2'b10, w, a, d};
        @(posedge clk_sys);
        bus[41] <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        bus[42:41] <= 2'b00;
        @(posedge clk_sys);
    endtask
    task automatic cmd(input logic [7:0] b);
        apb(1'b1, 8'h00, {24'h000000, b});
    endtask
    task automatic eop(input logic [7:0] op);
        cmd(8'hFE);
        cmd(op);
    endtask
    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Main sequence: reset, register setup, table rows, then awkward cases
    initial begin
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        apb(1'b0, 8'h08, 32'h0);
        `CHK(rd, 32'h00000001)
        apb(1'b0, 8'h14, 32'h0);
        `CHK(err, 1'b1)
        apb(1'b1, 8'h04, 32'h0);
        `CHK(err, 1'b1)
        eop(8'hA3);
        foreach (rows[i]) if (i < 4) cmd(8'h12 + 8'h22 * i[7:0]);
        eop(8'hB4);
        foreach (rows[i]) if (i < 4) cmd(8'h12 + 8'h22 * i[7:0]);
        foreach (rows[i]) begin
            eop(rows[i].op);
            apb(1'b0, 8'h04, 32'h0);
            `CHK(rd, {16'h0000, rows[i].e0})
            if (rows[i].n == 2'd2) apb(1'b0, 8'h04, 32'h0);
            if (rows[i].n == 2'd2) `CHK(rd, {16'h0000, rows[i].e1})
        end
        eop(8'hF9);
        eop(8'h93);
        apb(1'b0, 8'h04, 32'h0);
        `CHK(rd, 32'h00002434)
        eop(8'hF8);
        eop(8'hD4);
        eop(8'h92);
        apb(1'b0, 8'h04, 32'h0);
        `CHK(rd, 32'h00002468)
        apb(1'b0, 8'h04, 32'h0);
        `CHK(rd, 32'h0000ACF0)
        apb(1'b0, 8'h08, 32'h0);
        `CHK(rd[23:16], 8'h43)
        eop(8'hF5);
        cmd(8'h80);
        eop(8'h94);
        apb(1'b0, 8'h08, 32'h0);
        `CHK(rd[23:16], 8'h03)
        eop(8'h88);
        `CHK(math_req.op, 8'hD4)
        uf_active <= 1'b1;
        eop(8'h85);
        cmd(8'h00);
        `CHK(cond_done, 1'b1)
        @(posedge clk_sys);
        `CHK(cond_pass, 1'b1)
        eop(8'h86);
        cmd(8'h02);
        @(posedge clk_sys);
        `CHK(cond_pass, 1'b0)
        eop(8'h88);
        `CHK(math_req.op, 8'h88)
        uf_active <= 1'b0;
        eop(8'hFD);
        `CHK(trace_en, 1'b1)
        eop(8'hFE);
        cmd(8'h41);
        cmd(8'h42);
        cmd(8'h00);
        apb(1'b0, 8'h10, 32'h0);
        `CHK(rd, 32'h00004142)
        eop(8'hFC);
        `CHK(trace_en, 1'b0)
        `CHK(trace_code, 8'hFC)
        eop(8'hFF);
        apb(1'b0, 8'h0C, 32'h0);
        `CHK(rd, 32'h00000058)
        `CHK(seen_tv, 1)
        // Second reset in mid-run: selections and modes return to defaults
        reset_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        apb(1'b0, 8'h08, 32'h0);
        `CHK(rd, 32'h00000001)
        close_out();
    end
endmodule
